// >>> pkg/eaal_pkg.sv
// Constants and types for the error action and alarm type block.
// Assumes a single 50 MHz clock domain and an APB register slave.
package eaal_pkg;

  localparam int NCH = 4;
  localparam int NAL_PER_CH = 3;
  localparam int NAL = NCH * NAL_PER_CH;
  localparam int GRP_SIZE = 2;
  localparam int DW = 16;

  // Register byte offsets and alarm sub-register word indices
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SEL = 12'h004;
  localparam logic [11:0] OFS_HYST = 12'h008;
  localparam logic [11:0] OFS_DPB = 12'h00c;
  localparam logic [11:0] OFS_CH_BASE = 12'h040;
  localparam logic [11:0] OFS_AL_BASE = 12'h100;
  localparam logic [1:0] AL_SUB_TYPE = 2'h0;
  localparam logic [1:0] AL_SUB_X = 2'h1;
  localparam logic [1:0] AL_SUB_H = 2'h2;
  localparam logic [1:0] AL_SUB_L = 2'h3;

  // Command bits of the control register
  localparam int CMD_RUN = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_RSTERR = 2;
  localparam int CMD_SWRST = 3;

  // Selector register fields
  localparam int SEL_A_LSB = 0;
  localparam int SEL_C_LSB = 2;
  localparam int SEL_D_LSB = 4;
  localparam int SEL_GRAD = 8;
  localparam int SEL_W = 9;
  localparam int SEL_ACT_LSB = 16;
  localparam logic [SEL_W-1:0] SEL_RST = 9'h000;

  // Channel status bits
  localparam int ST_INPUT = 4;
  localparam int ST_ZC = 5;
  localparam int ST_COMM = 6;
  localparam int ST_LINK = 7;
  localparam int ST_OVERCUR = 8;
  localparam int ST_RELAY = 9;
  localparam int ST_HBREAK = 11;
  localparam int ST_STOPPED = 12;
  localparam int ST_FORCED = 13;
  localparam int ST_DLATCH = 14;

  // Threshold limits and reset values
  localparam logic signed [DW-1:0] TH_MIN = -16'sd1999;
  localparam logic signed [DW-1:0] TH_MAX = 16'sd9999;
  localparam logic [DW-1:0] TH_RST = 16'h0000;
  localparam logic [DW-1:0] HYST_RST = 16'h0002;
  localparam logic [1:0] DPB_RST = 2'h0;

  typedef enum logic [1:0] {
    ACT_REPORT = 2'b00,
    ACT_FORCE = 2'b01,
    ACT_STOP = 2'b10
  } eaal_act_t;

  typedef enum logic [3:0] {
    AT_OFF = 4'b0000,
    AT_UPLO = 4'b0001,
    AT_UPPER = 4'b0010,
    AT_LOWER = 4'b0011,
    AT_RANGE = 4'b0100,
    AT_UPLO_SB = 4'b0101,
    AT_UPPER_SB = 4'b0110,
    AT_LOWER_SB = 4'b0111,
    AT_ABS_UP = 4'b1000,
    AT_ABS_LO = 4'b1001,
    AT_ABS_UP_SB = 4'b1010,
    AT_ABS_LO_SB = 4'b1011
  } eaal_altype_t;

endpackage

// >>> pkg/eaal_alarm_if.sv
// Signals between the main block and one alarm evaluator.
// Assumes the main block drives all settings and the evaluator answers.
interface eaal_alarm_if;
  eaal_pkg::eaal_altype_t al_type;
  logic signed [15:0] x;
  logic signed [15:0] h;
  logic signed [15:0] l;
  logic signed [15:0] hyst;
  logic signed [15:0] pv;
  logic signed [15:0] sp;
  logic restart;
  logic alarm;
  modport ctl (output al_type, x, h, l, hyst, pv, sp, restart, input alarm);
  modport eval (input al_type, x, h, l, hyst, pv, sp, restart, output alarm);
endinterface

// >>> hw/eaal_alarm_eval.sv
// One alarm evaluator: type decode, thresholds and standby sequence.
// Assumes settings are stable and measured/target values are synchronous.
module eaal_alarm_eval (
  input wire logic i_clk,   // System clock
  input wire logic i_resetn, // Async reset, active low
  eaal_alarm_if.eval a      // Settings in, alarm out
);

  typedef struct packed {
    logic sb_ok;
    logic alarm;
  } eaal_ev_t;

  eaal_ev_t ev_ff;
  eaal_ev_t nxt_ev;
  logic signed [16:0] dev, sx_x, sx_h, sx_l, sx_pv, sx_hy;
  logic raw, sb, off;

  function automatic logic signed [16:0] sx(input logic signed [15:0] v);
    sx = {v[15], v};
  endfunction

  function automatic logic signed [16:0] mag(input logic signed [16:0] v);
    mag = (v < 0) ? -v : v;
  endfunction

  ////////////////////////////////////////////////////////////////
  // Raw alarm condition per type
  always_comb begin
    nxt_ev = ev_ff;
    sx_x = sx(a.x);
    sx_h = sx(a.h);
    sx_l = sx(a.l);
    sx_pv = sx(a.pv);
    sx_hy = sx(a.hyst);
    dev = sx_pv - sx(a.sp);
    raw = 1'b0;
    sb = 1'b0;
    off = 1'b0;
    case (a.al_type)
      eaal_pkg::AT_OFF: raw = 1'b0;
      eaal_pkg::AT_UPLO: raw = (dev > sx_h) || (dev < -sx_l);
      eaal_pkg::AT_UPPER: raw = dev > sx_x;
      eaal_pkg::AT_LOWER: raw = dev < -sx_x;
      eaal_pkg::AT_RANGE: raw = (dev <= sx_h) && (dev >= -sx_l);
      eaal_pkg::AT_UPLO_SB: begin
        raw = (dev > sx_h) || (dev < -sx_l);
        sb = 1'b1;
        // Band narrower than hysteresis would chatter, so hold off
        off = (sx_h + sx_l) < sx_hy;
        if ((sx_h < 0 && sx_l > 0 && mag(sx_h) >= mag(sx_l)) ||
            (sx_h > 0 && sx_l < 0 && mag(sx_h) <= mag(sx_l))) begin
          off = 1'b1;
        end
      end
      eaal_pkg::AT_UPPER_SB: begin
        raw = dev > sx_x;
        sb = 1'b1;
      end
      eaal_pkg::AT_LOWER_SB: begin
        raw = dev < -sx_x;
        sb = 1'b1;
      end
      eaal_pkg::AT_ABS_UP: raw = sx_pv > sx_x;
      eaal_pkg::AT_ABS_LO: raw = sx_pv < sx_x;
      eaal_pkg::AT_ABS_UP_SB: begin
        raw = sx_pv > sx_x;
        sb = 1'b1;
      end
      eaal_pkg::AT_ABS_LO_SB: begin
        raw = sx_pv < sx_x;
        sb = 1'b1;
      end
      default: raw = 1'b0;
    endcase
    // Standby: arm once the value has left the alarm region; arming wins over restart
    if (sb && !raw) begin
      nxt_ev.sb_ok = 1'b1;
    end else if (a.restart) begin
      nxt_ev.sb_ok = 1'b0;
    end
    nxt_ev.alarm = raw && !off && (!sb || ev_ff.sb_ok) && !a.restart;
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ev_ff <= '0;
    end else begin
      ev_ff <= nxt_ev;
    end
  end

  assign a.alarm = ev_ff.alarm;

endmodule

// >>> hw/eaal_top.sv
// Error reaction policy, alarm type decode and alarm thresholds.
// Assumes an APB master on I_CLK and error inputs synchronous to I_CLK.
//
// Decided for this implementation: the APB slave port and the address map.
module eaal_top (
  input wire logic I_CLK,                    // 50 MHz clock
  input wire logic I_RESETN,                 // Async reset, active low
  input wire logic I_PSEL,                   // APB select
  input wire logic I_PENABLE,                // APB enable
  input wire logic I_PWRITE,                 // APB direction
  input wire logic [11:0] I_PADDR,           // APB byte address
  input wire logic [31:0] I_PWDATA,          // APB write data
  output logic [31:0] O_PRDATA,              // APB read data
  output logic O_PREADY,                     // APB ready
  output logic O_PSLVERR,                    // APB error
  input wire logic I_LINK_ERR,               // Programless link error
  input wire logic [3:0] I_INPUT_ERR,        // Input error per channel
  input wire logic I_ZC_ERR,                 // Power unit zero-cross error
  input wire logic I_PWR_COMM_ERR,           // Power unit link error
  input wire logic [3:0] I_OVERCUR,          // Heater overcurrent
  input wire logic [3:0] I_HEATER_BREAK_ALARM, // Heater break
  input wire logic [3:0] I_RELAY_FAULT_ALARM,  // Relay failure
  input wire logic [3:0][15:0] I_MEASURED_VALUE, // Per channel
  input wire logic [3:0][15:0] I_TARGET_VALUE,   // Per channel
  output logic [3:0] O_CTRL_ACTIVE,          // Control running
  output logic [3:0] O_FORCE_MANIPULATED_OUTPUT, // Drive preset level
  output logic [11:0] O_ALARM                // Alarm outputs
);

  localparam int NCH = eaal_pkg::NCH;
  localparam int NAL = eaal_pkg::NAL;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [eaal_pkg::SEL_W-1:0] sel_pend;
    logic [eaal_pkg::SEL_W-1:0] sel_act;
    logic [15:0] hyst;
    logic [1:0] dpb;
    logic [NAL-1:0][3:0] al_type;
    logic [NAL-1:0][15:0] al_x;
    logic [NAL-1:0][15:0] al_h;
    logic [NAL-1:0][15:0] al_l;
    logic [NCH-1:0] stop;
    logic [NCH-1:0] active;
    logic [NCH-1:0] force_o;
    logic [NCH-1:0] d_latch;
    logic [NAL-1:0] alarm;
    logic sb_restart;
  } eaal_st_t;

  eaal_st_t st_ff;
  eaal_st_t nxt_st;

  logic [NAL-1:0] al_res;
  logic setup, commit, wr_ok;
  logic hit_ctrl, hit_sel, hit_hyst, hit_dpb, hit_ch, hit_al;
  logic [1:0] ch_idx;
  logic [3:0] al_idx;
  logic [1:0] al_sub;
  logic [31:0] rd;
  logic bad;
  logic all_stopped;
  logic cmd_run, cmd_stop, cmd_rsterr, cmd_swrst;
  eaal_pkg::eaal_act_t sel_a, sel_c, sel_d;
  logic gradient;
  logic [NCH-1:0] c_err, d_lvl, d_cur;
  logic [NCH-1:0] ch_stop, ch_force, g_stop, g_force;
  logic [NCH-1:0] stop_req, force_req;
  logic [15:0] wv;

  ////////////////////////////////////////////////////////////////
  // Alarm evaluators, three per channel
  generate
    for (genvar g = 0; g < NAL; g++) begin : g_al
      eaal_alarm_if u_if ();
      assign u_if.al_type = eaal_pkg::eaal_altype_t'(st_ff.al_type[g]);
      assign u_if.x = st_ff.al_x[g];
      assign u_if.h = st_ff.al_h[g];
      assign u_if.l = st_ff.al_l[g];
      assign u_if.hyst = st_ff.hyst;
      assign u_if.pv = I_MEASURED_VALUE[g / eaal_pkg::NAL_PER_CH];
      assign u_if.sp = I_TARGET_VALUE[g / eaal_pkg::NAL_PER_CH];
      assign u_if.restart = st_ff.sb_restart;
      assign al_res[g] = u_if.alarm;
      eaal_alarm_eval u_eval (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .a(u_if.eval)
      );
    end
  endgenerate

  // Range check for signed thresholds
  function automatic logic th_ok(input logic [15:0] v);
    th_ok = ($signed(v) >= eaal_pkg::TH_MIN) && ($signed(v) <= eaal_pkg::TH_MAX);
  endfunction

  ////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    hit_ctrl = (I_PADDR == eaal_pkg::OFS_CTRL);
    hit_sel = (I_PADDR == eaal_pkg::OFS_SEL);
    hit_hyst = (I_PADDR == eaal_pkg::OFS_HYST);
    hit_dpb = (I_PADDR == eaal_pkg::OFS_DPB);
    hit_ch = (I_PADDR[11:4] == eaal_pkg::OFS_CH_BASE[11:4]) && (I_PADDR[1:0] == 2'h0);
    ch_idx = I_PADDR[3:2];
    al_idx = I_PADDR[7:4];
    al_sub = I_PADDR[3:2];
    hit_al = (I_PADDR[11:8] == eaal_pkg::OFS_AL_BASE[11:8]) &&
             (I_PADDR[1:0] == 2'h0) && (al_idx < 4'(NAL));
  end

  ////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    nxt_st.sb_restart = 1'b0;
    wv = I_PWDATA[15:0];
    setup = I_PSEL && !I_PENABLE;
    commit = I_PSEL && I_PENABLE && st_ff.pready;
    wr_ok = commit && I_PWRITE && !st_ff.pslverr;
    all_stopped = &st_ff.stop;
    rd = 32'h0000_0000;
    bad = 1'b0;

    // Read data and refusal, prepared in the setup cycle
    if (hit_ctrl) begin
      rd[NCH-1:0] = st_ff.stop;
    end else if (hit_sel) begin
      rd[eaal_pkg::SEL_W-1:0] = st_ff.sel_pend;
      rd[eaal_pkg::SEL_ACT_LSB +: eaal_pkg::SEL_W] = st_ff.sel_act;
      // Selector changes only while everything is stopped
      bad = I_PWRITE && (!all_stopped || (I_PWDATA[1:0] == 2'h3) ||
            (I_PWDATA[3:2] == 2'h3) || (I_PWDATA[5:4] == 2'h3));
    end else if (hit_hyst) begin
      rd = {{16{st_ff.hyst[15]}}, st_ff.hyst};
    end else if (hit_dpb) begin
      rd[1:0] = st_ff.dpb;
    end else if (hit_ch) begin
      for (int k = 0; k < eaal_pkg::NAL_PER_CH; k++) begin
        rd[k] = st_ff.alarm[int'(ch_idx) * eaal_pkg::NAL_PER_CH + k];
      end
      rd[eaal_pkg::ST_INPUT] = I_INPUT_ERR[ch_idx];
      rd[eaal_pkg::ST_ZC] = I_ZC_ERR;
      rd[eaal_pkg::ST_COMM] = I_PWR_COMM_ERR;
      rd[eaal_pkg::ST_LINK] = I_LINK_ERR;
      rd[eaal_pkg::ST_OVERCUR] = I_OVERCUR[ch_idx];
      rd[eaal_pkg::ST_RELAY] = I_RELAY_FAULT_ALARM[ch_idx];
      rd[eaal_pkg::ST_HBREAK] = I_HEATER_BREAK_ALARM[ch_idx];
      rd[eaal_pkg::ST_STOPPED] = st_ff.stop[ch_idx];
      rd[eaal_pkg::ST_FORCED] = st_ff.force_o[ch_idx];
      rd[eaal_pkg::ST_DLATCH] = st_ff.d_latch[ch_idx];
    end else if (hit_al) begin
      case (al_sub)
        eaal_pkg::AL_SUB_TYPE: begin
          rd[3:0] = st_ff.al_type[al_idx];
          bad = I_PWRITE && (I_PWDATA[3:0] > eaal_pkg::AT_ABS_LO_SB);
        end
        eaal_pkg::AL_SUB_X: begin
          rd = {{16{st_ff.al_x[al_idx][15]}}, st_ff.al_x[al_idx]};
          bad = I_PWRITE && !th_ok(wv);
        end
        eaal_pkg::AL_SUB_H: begin
          rd = {{16{st_ff.al_h[al_idx][15]}}, st_ff.al_h[al_idx]};
          bad = I_PWRITE && !th_ok(wv);
        end
        eaal_pkg::AL_SUB_L: begin
          rd = {{16{st_ff.al_l[al_idx][15]}}, st_ff.al_l[al_idx]};
          bad = I_PWRITE && !th_ok(wv);
        end
        default: bad = 1'b1;
      endcase
    end else begin
      bad = 1'b1;
    end

    if (setup) begin
      nxt_st.pready = 1'b1;
      nxt_st.pslverr = bad;
      nxt_st.prdata = I_PWRITE ? 32'h0000_0000 : rd;
    end

    // Register writes take effect at the completing edge
    cmd_run = wr_ok && hit_ctrl && I_PWDATA[eaal_pkg::CMD_RUN];
    cmd_stop = wr_ok && hit_ctrl && I_PWDATA[eaal_pkg::CMD_STOP];
    cmd_rsterr = wr_ok && hit_ctrl && I_PWDATA[eaal_pkg::CMD_RSTERR];
    cmd_swrst = wr_ok && hit_ctrl && I_PWDATA[eaal_pkg::CMD_SWRST];
    if (wr_ok && hit_sel) begin
      nxt_st.sel_pend = I_PWDATA[eaal_pkg::SEL_W-1:0];
    end
    if (wr_ok && hit_hyst) begin
      nxt_st.hyst = wv;
    end
    if (wr_ok && hit_dpb) begin
      nxt_st.dpb = I_PWDATA[1:0];
    end
    if (wr_ok && hit_al) begin
      case (al_sub)
        eaal_pkg::AL_SUB_TYPE: nxt_st.al_type[al_idx] = I_PWDATA[3:0];
        eaal_pkg::AL_SUB_X: nxt_st.al_x[al_idx] = wv;
        eaal_pkg::AL_SUB_H: nxt_st.al_h[al_idx] = wv;
        eaal_pkg::AL_SUB_L: nxt_st.al_l[al_idx] = wv;
        default: nxt_st.al_x[al_idx] = st_ff.al_x[al_idx];
      endcase
    end

    // Active selectors; a pending change waits for software reset
    sel_a = eaal_pkg::eaal_act_t'(st_ff.sel_act[eaal_pkg::SEL_A_LSB +: 2]);
    sel_c = eaal_pkg::eaal_act_t'(st_ff.sel_act[eaal_pkg::SEL_C_LSB +: 2]);
    sel_d = eaal_pkg::eaal_act_t'(st_ff.sel_act[eaal_pkg::SEL_D_LSB +: 2]);
    gradient = st_ff.sel_act[eaal_pkg::SEL_GRAD];

    // Per-channel requests from selectors C and D
    for (int i = 0; i < NCH; i++) begin
      // One power unit feeds all channels, so its errors hit every one
      c_err[i] = I_INPUT_ERR[i] || I_ZC_ERR || I_PWR_COMM_ERR;
      d_lvl[i] = I_OVERCUR[i] || I_HEATER_BREAK_ALARM[i] ||
                 I_RELAY_FAULT_ALARM[i];
      // Current is not measured while stopped, so the error is latched
      d_cur[i] = d_lvl[i] || st_ff.d_latch[i];
      ch_stop[i] = (c_err[i] && (sel_c == eaal_pkg::ACT_STOP)) ||
                   (d_cur[i] && (sel_d == eaal_pkg::ACT_STOP));
      ch_force[i] = (c_err[i] && (sel_c == eaal_pkg::ACT_FORCE)) ||
                    (I_INPUT_ERR[i] && (sel_c == eaal_pkg::ACT_REPORT)) ||
                    (d_lvl[i] && (sel_d == eaal_pkg::ACT_FORCE));
    end

    // Gradient control widens the reaction to the whole group
    for (int i = 0; i < NCH; i++) begin
      g_stop[i] = ch_stop[i];
      g_force[i] = ch_force[i];
      for (int j = 0; j < NCH; j++) begin
        if (gradient && (j / eaal_pkg::GRP_SIZE == i / eaal_pkg::GRP_SIZE)) begin
          g_stop[i] = g_stop[i] || ch_stop[j];
          g_force[i] = g_force[i] || ch_force[j];
        end
      end
      stop_req[i] = g_stop[i] || (I_LINK_ERR && (sel_a == eaal_pkg::ACT_STOP));
      force_req[i] = g_force[i] || (I_LINK_ERR && (sel_a == eaal_pkg::ACT_FORCE));
    end

    // Stop and forced-output state; a new stop wins over run
    for (int i = 0; i < NCH; i++) begin
      // A live stop-class error outranks the clear below
      if (cmd_rsterr || cmd_swrst) begin
        nxt_st.d_latch[i] = 1'b0;
      end
      if (d_lvl[i] && (sel_d == eaal_pkg::ACT_STOP)) begin
        nxt_st.d_latch[i] = 1'b1;
      end
      if (cmd_run && !stop_req[i]) begin
        nxt_st.stop[i] = 1'b0;
      end
      if (cmd_stop || cmd_swrst || stop_req[i]) begin
        nxt_st.stop[i] = 1'b1;
      end
      // Stop outranks forced output, which outranks report-only
      nxt_st.force_o[i] = force_req[i] && !nxt_st.stop[i];
      nxt_st.active[i] = !nxt_st.stop[i];
    end

    // Software reset loads the pending selectors
    if (cmd_swrst) begin
      nxt_st.sel_act = st_ff.sel_pend;
      nxt_st.sb_restart = 1'b1;
    end

    nxt_st.alarm = al_res;
  end

  ////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_ff <= '0;
      st_ff.sel_pend <= eaal_pkg::SEL_RST;
      st_ff.sel_act <= eaal_pkg::SEL_RST;
      st_ff.hyst <= eaal_pkg::HYST_RST;
      st_ff.dpb <= eaal_pkg::DPB_RST;
      st_ff.stop <= '1;
      for (int i = 0; i < NAL; i++) begin
        st_ff.al_type[i] <= eaal_pkg::AT_UPPER;
        st_ff.al_x[i] <= eaal_pkg::TH_RST;
        st_ff.al_h[i] <= eaal_pkg::TH_RST;
        st_ff.al_l[i] <= eaal_pkg::TH_RST;
      end
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign O_PRDATA = st_ff.prdata;
  assign O_PREADY = st_ff.pready;
  assign O_PSLVERR = st_ff.pslverr;
  assign O_CTRL_ACTIVE = st_ff.active;
  assign O_FORCE_MANIPULATED_OUTPUT = st_ff.force_o;
  assign O_ALARM = st_ff.alarm;

endmodule

// >>> tb/eaal_checker.sv
// Port-level assertions for the error action and alarm block.
// Assumes it is bound onto eaal_top; one clock, async active-low reset.
module eaal_checker (
  input wire logic I_CLK, // Clock
  input wire logic I_RESETN, // Reset, active low
  input wire logic I_PSEL, // APB select
  input wire logic I_PENABLE, // APB enable
  input wire logic I_PWRITE, // APB direction
  input wire logic [11:0] I_PADDR, // APB address
  input wire logic [31:0] I_PWDATA, // APB write data
  input wire logic [31:0] O_PRDATA, // APB read data
  input wire logic O_PREADY, // APB ready
  input wire logic O_PSLVERR, // APB error
  input wire logic I_LINK_ERR, // Link error
  input wire logic [3:0] I_INPUT_ERR, // Input errors
  input wire logic I_ZC_ERR, // Zero-cross error
  input wire logic I_PWR_COMM_ERR, // Power unit link error
  input wire logic [3:0] I_OVERCUR, // Overcurrent
  input wire logic [3:0] I_HEATER_BREAK_ALARM, // Heater break
  input wire logic [3:0] I_RELAY_FAULT_ALARM, // Relay fault
  input wire logic [3:0] O_CTRL_ACTIVE, // Running channels
  input wire logic [3:0] O_FORCE_MANIPULATED_OUTPUT // Forced channels
);
  default clocking @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);
  // Any error cause at all, for the forced-output check
  logic any_err;
  assign any_err = I_LINK_ERR || (I_INPUT_ERR != 4'h0) || I_ZC_ERR || I_PWR_COMM_ERR ||
    (I_OVERCUR != 4'h0) || (I_HEATER_BREAK_ALARM != 4'h0) || (I_RELAY_FAULT_ALARM != 4'h0);
  ////////////////////////////////////////////////////////////////
  // Bus handshake: one access cycle, no wait states
  ready_after_setup_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing after setup");
  ready_single_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
    else $error("ready outside access phase");
  err_with_ready_a: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  write_data_zero_a: assert property (O_PREADY && I_PWRITE |-> O_PRDATA == 32'h0)
    else $error("read data not zero on write");
  unmapped_read_a: assert property (O_PREADY && !I_PWRITE && I_PADDR == 12'h020
    |-> O_PSLVERR && O_PRDATA == 32'h0) else $error("unmapped read accepted");
  // Stop lands on the commit edge and is sampled at the next edge
  stop_cmd_a: assert property (O_PREADY && I_PWRITE && I_PADDR == 12'h000 && I_PWDATA[1]
    && !O_PSLVERR |-> ##1 O_CTRL_ACTIVE == 4'h0) else $error("stop command ignored");
  // Forcing without any error cause would leak the preset level
  force_needs_error_a: assert property (O_FORCE_MANIPULATED_OUTPUT != 4'h0 |->
    $past(any_err)) else $error("force without error");
  cover property (O_FORCE_MANIPULATED_OUTPUT == 4'hf);
  cover property (O_PSLVERR);
  cover property ($fell(O_CTRL_ACTIVE[0]));
endmodule

bind eaal_top eaal_checker eaal_checker_i (.I_CLK, .I_RESETN, .I_PSEL, .I_PENABLE,
  .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .I_LINK_ERR,
  .I_INPUT_ERR, .I_ZC_ERR, .I_PWR_COMM_ERR, .I_OVERCUR, .I_HEATER_BREAK_ALARM,
  .I_RELAY_FAULT_ALARM, .O_CTRL_ACTIVE, .O_FORCE_MANIPULATED_OUTPUT);

// >>> tb/eaal_host.sv
// APB master standing in for the supervisory host.
// Assumes each call starts just after a rising edge of clk.
module eaal_host (
  input wire logic clk, // Clock
  input wire logic pready, // Slave ready
  output logic psel, // Select
  output logic penable, // Enable
  output logic pwrite, // Direction
  output logic [11:0] paddr, // Byte address
  output logic [31:0] pwdata // Write data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; released address and data show inverted junk, not the old value
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // This wait ends on pready; there is no timeout here, only the bench's own
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule

// >>> tb/test_error_action_and_alarm_type_logic.sv
// Self-checking bench for the error action and alarm block.
// Assumes eaal_host drives the bus and eaal_checker is bound to the top.
module test_error_action_and_alarm_type_logic;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic e; logic [31:0] d; logic [31:0] m;} eaal_note_t;
  localparam logic [11:0] ctl = eaal_pkg::OFS_CTRL;
  localparam logic [11:0] sel = eaal_pkg::OFS_SEL;
  localparam logic [11:0] alb = eaal_pkg::OFS_AL_BASE;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel, pen, pwr, rdy, serr, lk, zc, pc;
  logic [11:0] pa, alm;
  logic [31:0] pwd, prd;
  logic [3:0] ie, hb, act, frc, oc, rf;
  logic [3:0][15:0] pv, sp;
  eaal_note_t q[$];
  eaal_note_t nt;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 19136;
  int v;
  int tv[4] = '{9999, 10000, -2000, -1999};
  logic te[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  eaal_top eaal_top_i (.I_CLK(clk), .I_RESETN(rstn), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy),
    .O_PSLVERR(serr), .I_LINK_ERR(lk), .I_INPUT_ERR(ie), .I_ZC_ERR(zc),
    .I_PWR_COMM_ERR(pc), .I_OVERCUR(oc), .I_HEATER_BREAK_ALARM(hb),
    .I_RELAY_FAULT_ALARM(rf), .I_MEASURED_VALUE(pv), .I_TARGET_VALUE(sp),
    .O_CTRL_ACTIVE(act), .O_FORCE_MANIPULATED_OUTPUT(frc), .O_ALARM(alm));
  eaal_host eaal_host_i (.clk(clk), .pready(rdy), .psel(psel), .penable(pen),
    .pwrite(pwr), .paddr(pa), .pwdata(pwd));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic conclude();
    if (q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Note the answer first, then run the transfer
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic e, input logic [31:0] x, input logic [31:0] m);
    q.push_back('{e, x, m});
    eaal_host_i.xfer(w, a, d);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    xf(1'b1, a, d, e, 32'h0, 32'hffffffff);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m);
    xf(1'b0, a, 32'h0, 1'b0, x, m);
  endtask
  // Errors in, then running and forced channels out
  task automatic ev(input logic [3:0] i, input logic [3:0] h, input logic l,
    input logic z, input logic [3:0] a, input logic [3:0] f);
    ie <= i;
    hb <= h;
    lk <= l;
    zc <= z;
    repeat (3) @(posedge clk);
    chk("ctrl_active", 32'(a), 32'(act));
    chk("force", 32'(f), 32'(frc));
  endtask
  task automatic al(input logic [15:0] p, input logic e);
    pv[0] <= p;
    repeat (4) @(posedge clk);
    chk("alarm0", 32'(e), 32'(alm[0]));
  endtask
  // Selectors only load while stopped and act after software reset
  task automatic cfg(input logic [31:0] s);
    wr(ctl, 32'h2, 1'b0);
    wr(sel, s, 1'b0);
    wr(ctl, 32'h8, 1'b0);
    wr(ctl, 32'h1, 1'b0);
    rd(sel, s | (s << 16), 32'h01ff01ff);
  endtask
  ////////////////////////////////////////////////////////////////
  // Answer monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rstn && rdy === 1'b1) begin
      if (q.size() == 0) begin
        chk("note", 32'h0, 32'h1);
      end else begin
        nt = q.pop_front();
        chk("pslverr", 32'(nt.e), 32'(serr));
        chk("prdata", nt.d & nt.m, prd & nt.m);
      end
    end
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    {ie, hb, lk, zc, pc, oc, rf} = '0;
    pv = '0;
    sp = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(sel, 32'h0, 32'hffffffff);
    wr(alb, 32'd12, 1'b1);
    rd(alb, 32'd2, 32'hffffffff);
    rd(alb + 12'h4, 32'h0, 32'hffffffff);
    rd(alb + 12'h8, 32'h0, 32'hffffffff);
    xf(1'b0, 12'h020, 32'h0, 1'b1, 32'h0, 32'hffffffff);
    wr(eaal_pkg::OFS_DPB, 32'h3, 1'b0);
    rd(eaal_pkg::OFS_DPB, 32'h3, 32'h3);
    foreach (tv[k]) for (int s = 1; s < 4; s++) wr(alb + 12'(4 * s), 32'(tv[k]), te[k]);
    for (int s = 1; s < 4; s++) rd(alb + 12'(4 * s), 32'hfffff831, 32'hffffffff);
    wr(ctl, 32'h1, 1'b0);
    wr(sel, 32'h4, 1'b1);
    wr(ctl, 32'h2, 1'b0);
    wr(sel, 32'h4, 1'b0);
    rd(sel, 32'h4, 32'h01ff01ff);
    cfg(32'h0);
    ev(4'h1, 4'h0, 1'b0, 1'b0, 4'hf, 4'h1);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'hf, 4'h0);
    cfg(32'h4);
    ev(4'h2, 4'h0, 1'b0, 1'b0, 4'hf, 4'h2);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'hf, 4'h0);
    pc <= 1'b1;
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'hf, 4'hf);
    pc <= 1'b0;
    cfg(32'h8);
    ev(4'h2, 4'h0, 1'b0, 1'b0, 4'hd, 4'h0);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'hd, 4'h0);
    wr(ctl, 32'h1, 1'b0);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'hf, 4'h0);
    cfg(32'h108);
    ev(4'h4, 4'h0, 1'b0, 1'b0, 4'h3, 4'h0);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'h3, 4'h0);
    wr(ctl, 32'h1, 1'b0);
    ev(4'h0, 4'h0, 1'b0, 1'b1, 4'h0, 4'h0);
    cfg(32'h20);
    ev(4'h0, 4'h1, 1'b0, 1'b0, 4'he, 4'h0);
    rd(12'h040, 32'h5800, 32'h5800);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'he, 4'h0);
    wr(ctl, 32'h1, 1'b0);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'he, 4'h0);
    wr(ctl, 32'h4, 1'b0);
    wr(ctl, 32'h1, 1'b0);
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'hf, 4'h0);
    oc <= 4'h2;
    rf <= 4'h4;
    ev(4'h0, 4'h0, 1'b0, 1'b0, 4'h9, 4'h0);
    {oc, rf} <= '0;
    cfg(32'h9);
    ev(4'h0, 4'h0, 1'b1, 1'b0, 4'hf, 4'hf);
    ev(4'h1, 4'h0, 1'b1, 1'b0, 4'he, 4'he);
    // Alarm 0 of channel 0, target value held at zero
    wr(alb + 12'h8, 32'd10, 1'b0);
    wr(alb + 12'hc, 32'd10, 1'b0);
    wr(alb, 32'd1, 1'b0);
    al(16'd20, 1'b1);
    al(16'd0, 1'b0);
    al(-16'sd20, 1'b1);
    wr(alb, 32'd4, 1'b0);
    al(16'd0, 1'b1);
    al(16'd20, 1'b0);
    wr(alb + 12'h4, 32'd5, 1'b0);
    wr(alb, 32'd2, 1'b0);
    for (int k = 0; k < 8; k++) begin
      v = $random(seed) % 100;
      al(16'(v), v > 5);
    end
    pv[0] <= 16'd50;
    wr(alb, 32'd6, 1'b0);
    wr(ctl, 32'h8, 1'b0);
    al(16'd50, 1'b0);
    al(16'd0, 1'b0);
    al(16'd50, 1'b1);
    wr(eaal_pkg::OFS_HYST, 32'd32, 1'b0);
    wr(alb, 32'd5, 1'b0);
    al(16'd0, 1'b0);
    al(16'd50, 1'b0);
    // Negative hysteresis keeps the overlap check quiet, so only the sign case acts
    wr(eaal_pkg::OFS_HYST, 32'hfffffff8, 1'b0);
    wr(alb + 12'h8, 32'hfffffffb, 1'b0);
    wr(alb + 12'hc, 32'd5, 1'b0);
    al(16'd0, 1'b0);
    al(16'd50, 1'b0);
    wr(alb, 32'd0, 1'b0);
    al(16'd50, 1'b0);
    conclude();
  end
endmodule
